// [pfw_defs.vh]
`ifndef PFW_DEFS_VH
`define PFW_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFW_OFF_TABLE_LATCH  8'h00
`define PFW_OFF_TABLE_PTR    8'h04
`define PFW_OFF_TABLE_WRITE  8'h08
`define PFW_OFF_NVM_CONTROL  8'h0c
`define PFW_OFF_NVM_UNLOCK   8'h10
`define PFW_OFF_FLAGS_TWO    8'h14
`define PFW_OFF_FLAGS_MASK   8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFW_BIT_PROG_SPACE   7
`define PFW_BIT_CFG_SPACE    6
`define PFW_BIT_WRITE_PERMIT 2
`define PFW_BIT_WRITE_GO     1
`define PFW_BIT_WRITE_DONE   4
`define PFW_BIT_POST_INC     0

// ----------------------------------------
// Reset values and keys
// ----------------------------------------
`define PFW_HOLD_RESET       8'hff
`define PFW_CTRL_RESET       8'h00
`define PFW_FLAGS_RESET      8'h00
`define PFW_FLAGS_IMPL       8'h10
`define PFW_UNLOCK_KEY1      8'h55
`define PFW_UNLOCK_KEY2      8'haa

// ----------------------------------------
// Row geometry
// ----------------------------------------
`define PFW_ROW_BYTES        8
`define PFW_ROW_WORDS        4

// ----------------------------------------
// Timing
// ----------------------------------------
`define PFW_CLK_PERIOD_NS    100
`define PFW_WRITE_TIME_NS    2000000
`define PFW_WRITE_CYCLES     (`PFW_WRITE_TIME_NS / `PFW_CLK_PERIOD_NS)

`endif

// [pfw_prog_timer.v]
`timescale 1ns/1ps

// ----------------------------------------
// Programming timer for the long write
// ----------------------------------------
module pfw_prog_timer #(
	parameter integer CYCLES = 20000,
	parameter integer CW     = 16
) (
	// Clock and reset
	input  wire          hclk,
	input  wire          hresetn,
	// Control
	input  wire          start,
	// Status
	output reg           busy,
	output reg           done
);

	reg [CW-1:0] count;    // Cycles left in the write

	// Counts down CYCLES cycles, then pulses done
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= {CW{1'b0}};
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				// Load the full duration
				count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
				busy  <= 1'b1;
			end else if (busy) begin
				if (count == {CW{1'b0}}) begin
					// Timer alone ends the write
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

// [pfw_row_writer.v]
`timescale 1ns/1ps
`include "pfw_defs.vh"

// What this block does
// - Programs only whole eight byte rows
// - Eight byte holding registers feed programming
// - Table writes touch holding registers only
// - Long write stalls core, timer ends it
// - Holding registers return to FFh
// - FFh holding byte leaves flash byte
// - Unlock keys 55h then AAh before go
// - Core stalled about 2 ms per write
module pfw_row_writer #(
	parameter integer TP_W         = 12,
	parameter integer WRITE_CYCLES = `PFW_WRITE_CYCLES
) (
	// Clock and reset
	input  wire                hclk,
	input  wire                hresetn,
	// AHB-Lite slave
	input  wire                hsel,
	input  wire [7:0]          haddr,
	input  wire [1:0]          htrans,
	input  wire                hwrite,
	input  wire [2:0]          hsize,
	input  wire [31:0]         hwdata,
	input  wire                hready,
	output wire                hreadyout,
	output wire                hresp,
	output reg  [31:0]         hrdata,
	// Core and interrupt
	output reg                 core_stall,
	output wire                irq,
	// Flash array programming port
	output reg                 flash_prog,
	output reg  [TP_W-4:0]     flash_row_addr,
	output reg  [63:0]         flash_wdata,
	output reg  [7:0]          flash_byte_en
);

	// ----------------------------------------
	// Local states
	// ----------------------------------------
	localparam [2:0] UL_IDLE = 3'b001;  // No key seen
	localparam [2:0] UL_KEY1 = 3'b010;  // First key seen
	localparam [2:0] UL_OPEN = 3'b100;  // Go may be set
	localparam [1:0] SQ_IDLE = 2'b01;   // Loading holding registers
	localparam [1:0] SQ_BUSY = 2'b10;   // Long write running

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Address compare on word offset
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a[7:2] == off[7:2]);
		end
	endfunction

	// Byte enable: FFh means leave alone
	function byte_en;
		input [7:0] b;
		begin
			byte_en = (b != `PFW_HOLD_RESET);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [7:0]      hold [0:`PFW_ROW_BYTES-1]; // Holding registers
	reg  [7:0]      table_latch;               // One byte latch
	reg  [TP_W-1:0] table_ptr;                 // Table pointer
	reg  [7:0]      nvm_control_reg;           // Control bits
	reg  [7:0]      flags_two;                 // Sticky status
	reg  [7:0]      flags_mask;                // Interrupt mask
	reg  [2:0]      unlock_state;              // Key tracker
	reg  [1:0]      seq_state;                 // Sequencer state
	reg             dp_write;                  // Write data phase pending
	reg  [7:0]      dp_addr;                   // Latched address
	wire            timer_busy;                // Timer running
	wire            timer_done;                // Timer finished
	wire            addr_ok;                   // Address phase accepted
	wire            rd_flags;                  // Read of status register
	wire            wr_latch;                  // Write to latch
	wire            wr_ptr;                    // Write to pointer
	wire            wr_table;                  // Table write strobe
	wire            wr_ctrl;                   // Write to control
	wire            wr_unlock;                 // Write to unlock
	wire            wr_mask;                   // Write to mask
	wire            go_ok;                     // Write go accepted
	wire [7:0]      wd;                        // Low byte of data
	integer         i;                         // Holding register index
	integer         j;                         // Row capture index

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	// Zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel && hready && htrans[1];
	assign rd_flags  = addr_ok && !hwrite && hit(haddr, `PFW_OFF_FLAGS_TWO);
	assign wd        = hwdata[7:0];
	assign wr_latch  = dp_write && hit(dp_addr, `PFW_OFF_TABLE_LATCH);
	assign wr_ptr    = dp_write && hit(dp_addr, `PFW_OFF_TABLE_PTR);
	assign wr_table  = dp_write && hit(dp_addr, `PFW_OFF_TABLE_WRITE);
	assign wr_ctrl   = dp_write && hit(dp_addr, `PFW_OFF_NVM_CONTROL);
	assign wr_unlock = dp_write && hit(dp_addr, `PFW_OFF_NVM_UNLOCK);
	assign wr_mask   = dp_write && hit(dp_addr, `PFW_OFF_FLAGS_MASK);

	// Go needs keys, program space and permit
	assign go_ok = wr_ctrl && wd[`PFW_BIT_WRITE_GO] && (unlock_state == UL_OPEN)
		&& wd[`PFW_BIT_PROG_SPACE] && !wd[`PFW_BIT_CFG_SPACE]
		&& wd[`PFW_BIT_WRITE_PERMIT] && (seq_state == SQ_IDLE);

	// Latch address phase of writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else begin
			dp_write <= addr_ok && hwrite;
			if (addr_ok) begin
				dp_addr <= haddr;
			end
		end
	end

	// Read data registered in address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			case ({2'b00, haddr[7:2]})
				`PFW_OFF_TABLE_LATCH >> 2: begin
					hrdata <= {24'h000000, table_latch};
				end
				`PFW_OFF_TABLE_PTR >> 2: begin
					hrdata <= {{(32-TP_W){1'b0}}, table_ptr};
				end
				`PFW_OFF_NVM_CONTROL >> 2: begin
					hrdata <= {24'h000000, nvm_control_reg};
				end
				`PFW_OFF_FLAGS_TWO >> 2: begin
					hrdata <= {24'h000000, flags_two};
				end
				`PFW_OFF_FLAGS_MASK >> 2: begin
					hrdata <= {24'h000000, flags_mask};
				end
				default: begin
					// Unmapped and write-only read zero
					hrdata <= 32'h00000000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Table latch, pointer, holding registers
	// ----------------------------------------

	// Latch and pointer updates
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			table_latch <= 8'h00;
			table_ptr   <= {TP_W{1'b0}};
		end else if (seq_state == SQ_IDLE) begin
			if (wr_latch) begin
				table_latch <= wd;
			end
			if (wr_ptr) begin
				table_ptr <= hwdata[TP_W-1:0];
			end else if (wr_table && wd[`PFW_BIT_POST_INC]) begin
				// Auto increment after a table write
				table_ptr <= table_ptr + {{(TP_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Short writes fill holding registers only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < `PFW_ROW_BYTES; i = i + 1) begin
				hold[i] <= `PFW_HOLD_RESET;
			end
		end else if (timer_done) begin
			for (i = 0; i < `PFW_ROW_BYTES; i = i + 1) begin
				hold[i] <= `PFW_HOLD_RESET;
			end
		end else if (wr_table && (seq_state == SQ_IDLE)) begin
			hold[table_ptr[2:0]] <= table_latch;
		end
	end

	// ----------------------------------------
	// Control and unlock
	// ----------------------------------------

	// Key sequence tracker
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock_state <= UL_IDLE;
		end else begin
			case (unlock_state)
				UL_IDLE: begin
					if (wr_unlock && (wd == `PFW_UNLOCK_KEY1)) begin
						unlock_state <= UL_KEY1;
					end
				end
				UL_KEY1: begin
					if (wr_unlock) begin
						unlock_state <= (wd == `PFW_UNLOCK_KEY2) ? UL_OPEN : UL_IDLE;
					end else if (dp_write) begin
						unlock_state <= UL_IDLE;
					end
				end
				UL_OPEN: begin
					// Any further write closes the lock
					if (dp_write) begin
						unlock_state <= UL_IDLE;
					end
				end
				default: begin
					unlock_state <= UL_IDLE;
				end
			endcase
		end
	end

	// Control register; go cleared by hardware
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_control_reg <= `PFW_CTRL_RESET;
		end else if (timer_done) begin
			nvm_control_reg[`PFW_BIT_WRITE_GO] <= 1'b0;
		end else if (wr_ctrl && (seq_state == SQ_IDLE)) begin
			nvm_control_reg[`PFW_BIT_PROG_SPACE]   <= wd[`PFW_BIT_PROG_SPACE];
			nvm_control_reg[`PFW_BIT_CFG_SPACE]    <= wd[`PFW_BIT_CFG_SPACE];
			nvm_control_reg[`PFW_BIT_WRITE_PERMIT] <= wd[`PFW_BIT_WRITE_PERMIT];
			nvm_control_reg[`PFW_BIT_WRITE_GO]     <= go_ok;
		end
	end

	// ----------------------------------------
	// Long write sequencer
	// ----------------------------------------

	// Program timer instance
	pfw_prog_timer #(
		.CYCLES (WRITE_CYCLES),
		.CW     (32)
	) u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (go_ok),
		.busy    (timer_busy),
		.done    (timer_done)
	);

	// Whole row captured and programmed at once
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_state      <= SQ_IDLE;
			core_stall     <= 1'b0;
			flash_prog     <= 1'b0;
			flash_row_addr <= {(TP_W-3){1'b0}};
			flash_wdata    <= 64'h0000000000000000;
			flash_byte_en  <= 8'h00;
		end else begin
			case (seq_state)
				SQ_IDLE: begin
					if (go_ok) begin
						seq_state      <= SQ_BUSY;
						core_stall     <= 1'b1;
						flash_prog     <= 1'b1;
						// Row taken from pointer; core keeps it in range
						flash_row_addr <= table_ptr[TP_W-1:3];
						for (j = 0; j < `PFW_ROW_BYTES; j = j + 1) begin
							flash_wdata[j*8 +: 8] <= hold[j];
							flash_byte_en[j]      <= byte_en(hold[j]);
						end
					end
				end
				SQ_BUSY: begin
					if (timer_done) begin
						// Timer ends the stall
						seq_state     <= SQ_IDLE;
						core_stall    <= 1'b0;
						flash_prog    <= 1'b0;
						flash_byte_en <= 8'h00;
					end
				end
				default: begin
					seq_state <= SQ_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------

	// Sticky done flag, read clears, set wins
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_two  <= `PFW_FLAGS_RESET;
			flags_mask <= `PFW_FLAGS_RESET;
		end else begin
			flags_two[`PFW_BIT_WRITE_DONE] <= timer_done
				|| (flags_two[`PFW_BIT_WRITE_DONE] && !rd_flags);
			if (wr_mask) begin
				flags_mask <= wd & `PFW_FLAGS_IMPL;
			end
		end
	end

	// Level interrupt from unmasked flags
	assign irq = |(flags_two & flags_mask);

endmodule

// [pfw_flash_model.sv]
`timescale 1ns/1ps
// ----
// Flash array model behind the programming port
// ----
module pfw_flash_model #(
	parameter integer AW = 9
) (
	// Clock
	input wire logic          hclk,
	// Programming port
	input wire logic          flash_prog,
	input wire logic [AW-1:0] flash_row_addr,
	input wire logic [63:0]   flash_wdata,
	input wire logic [7:0]    flash_byte_en
);
	logic [63:0] mem [0:(1<<AW)-1]; // Erased rows read all ones
	logic        prog_d;            // Strobe seen last cycle
	// Array starts erased
	initial begin
		foreach (mem[i]) mem[i] = {8{8'hff}};
	end
	// Whole row at once, enabled bytes only, bits can only clear
	always @(posedge hclk) begin
		prog_d <= flash_prog;
		if (flash_prog && !prog_d) begin
			for (int i = 0; i < 8; i++) begin
				if (flash_byte_en[i]) begin
					mem[flash_row_addr][8*i +: 8] <=
						mem[flash_row_addr][8*i +: 8] & flash_wdata[8*i +: 8];
				end
			end
		end
	end
endmodule

// [pfw_row_writer_chk.sv]
`timescale 1ns/1ps
// ----
// Port checker for the row writer
// ----
module pfw_row_writer_chk #(
	parameter integer TP_W         = 12,
	parameter integer WRITE_CYCLES = 8
) (
	// Clock and reset
	input wire logic            hclk,
	input wire logic            hresetn,
	// Bus
	input wire logic            hsel,
	input wire logic [7:0]      haddr,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic [31:0]     hwdata,
	input wire logic            hready,
	// Core, interrupt and flash port
	input wire logic            core_stall,
	input wire logic            irq,
	input wire logic            flash_prog,
	input wire logic [TP_W-4:0] flash_row_addr,
	input wire logic [63:0]     flash_wdata,
	input wire logic [7:0]      flash_byte_en
);
	logic [15:0] stall_cnt; // Cycles of the running stall
	logic        wr_ctl_d;  // Control write in data phase
	logic [7:0]  exp_en;    // Bytes that differ from all ones
	// Stall counter and control write tracker
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stall_cnt <= 16'h0000;
			wr_ctl_d  <= 1'b0;
		end else begin
			stall_cnt <= core_stall ? stall_cnt + 16'h0001 : 16'h0000;
			wr_ctl_d  <= hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h03;
		end
	end
	// Expected byte enables
	always_comb begin
		for (int i = 0; i < 8; i++) exp_en[i] = flash_wdata[8*i +: 8] != 8'hff;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_stall_len; $fell(core_stall) |-> stall_cnt == WRITE_CYCLES + 1; endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
	property p_stall_max; core_stall |-> stall_cnt <= WRITE_CYCLES; endproperty
	a_stall_max: assert property (p_stall_max) else $error("stall overruns");
	property p_prog; flash_prog == core_stall; endproperty
	a_prog: assert property (p_prog) else $error("program strobe apart from stall");
	property p_en_idle; !flash_prog |-> flash_byte_en == 8'h00; endproperty
	a_en_idle: assert property (p_en_idle) else $error("byte enable while idle");
	property p_en_match; flash_prog |-> flash_byte_en == exp_en; endproperty
	a_en_match: assert property (p_en_match) else $error("byte enable wrong");
	property p_hold; flash_prog && $past(flash_prog) |-> $stable(flash_wdata) && $stable(flash_row_addr); endproperty
	a_hold: assert property (p_hold) else $error("row data moved");
	property p_go; $rose(core_stall) |-> $past(wr_ctl_d) && ($past(hwdata) & 32'hc6) == 32'h86; endproperty
	a_go: assert property (p_go) else $error("write without go");
	property p_irq_clr;
		hsel && hready && htrans[1] && !hwrite && haddr[7:2] == 6'h05 && !core_stall |=> !irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("flag read left irq");
endmodule
bind pfw_row_writer pfw_row_writer_chk #(.TP_W(TP_W), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .core_stall,
	.irq, .flash_prog, .flash_row_addr, .flash_wdata, .flash_byte_en);

// [tb_top.sv]
`timescale 1ns/1ps
`include "pfw_defs.vh"
// ----
// Testbench for the row writer
// ----
module tb_top;
	localparam integer WC = 8; // Shortened write time
	logic        hclk, hresetn, hsel, hwrite;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, rd;
	wire         hready, hresp, core_stall, irq, flash_prog;
	wire  [31:0] hrdata;
	wire  [8:0]  flash_row_addr;
	wire  [63:0] flash_wdata;
	wire  [7:0]  flash_byte_en;
	int          failures, n_checks;
	pfw_row_writer #(.TP_W(12), .WRITE_CYCLES(WC)) DUT (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
		.core_stall, .irq, .flash_prog, .flash_row_addr, .flash_wdata, .flash_byte_en);
	pfw_flash_model u_flash (.hclk, .flash_prog, .flash_row_addr, .flash_wdata, .flash_byte_en);
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// Verdict and end of run
	task automatic summarize;
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Next edge with ready high, bounded
	task automatic edge_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++i > 20) begin
				failures++;
				$display("wrong value at %0t: bus hang", $time);
				summarize();
			end
			@(posedge hclk);
		end
	endtask
	// One single AHB transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		edge_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		edge_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Set up, unlock, then write control
	task automatic arm(input logic [7:0] key2, input logic [7:0] ctl);
		wr(`PFW_OFF_NVM_CONTROL, 32'h84);
		wr(`PFW_OFF_NVM_UNLOCK, 32'h55);
		wr(`PFW_OFF_NVM_UNLOCK, {24'h0, key2});
		wr(`PFW_OFF_NVM_CONTROL, {24'h0, ctl});
		#1;
	endtask
	// Length of the running stall
	task automatic wait_write(output int n);
		n = 0;
		while (core_stall === 1'b1 && n < 100) begin
			@(posedge hclk);
			#1;
			n++;
		end
		// A write that never ends closes the run
		if (core_stall === 1'b1) begin
			failures++;
			$display("wrong value at %0t: write never ended", $time);
			summarize();
		end
		// Back on the edge for the next request
		@(posedge hclk);
	endtask
	task automatic t_reset;
		chk(irq, 0);
		chk(hresp, 1'b0);
		chk(flash_byte_en, 0);
		rd_chk(`PFW_OFF_NVM_CONTROL, 32'h0);
		rd_chk(`PFW_OFF_FLAGS_TWO, 32'h0);
		rd_chk(8'h1c, 32'h0);
	endtask
	task automatic t_program;
		int n;
		wr(`PFW_OFF_FLAGS_MASK, 32'h10);
		wr(`PFW_OFF_TABLE_PTR, 32'h10);
		for (int i = 0; i < 8; i++) begin
			wr(`PFW_OFF_TABLE_LATCH, (i == 3) ? 32'hff : 32'h30 + i);
			wr(`PFW_OFF_TABLE_WRITE, 32'h1);
		end
		rd_chk(`PFW_OFF_TABLE_PTR, 32'h18);
		wr(`PFW_OFF_TABLE_PTR, 32'h17);
		chk(u_flash.mem[2], {8{8'hff}});
		arm(8'haa, 8'h86);
		chk(flash_byte_en, 8'hf7);
		chk(flash_row_addr, 9'h002);
		wait_write(n);
		chk(n, WC + 1);
		chk(u_flash.mem[2], 64'h3736_3534_ff32_3130);
		chk(irq, 1);
		rd_chk(`PFW_OFF_FLAGS_TWO, 32'h10);
		chk(irq, 0);
		rd_chk(`PFW_OFF_FLAGS_TWO, 32'h0);
	endtask
	// Wrong second key, then missing permit
	task automatic t_refused;
		logic [7:0] k [2] = '{8'h56, 8'haa};
		logic [7:0] c [2] = '{8'h86, 8'h82};
		for (int i = 0; i < 2; i++) begin
			arm(k[i], c[i]);
			chk(core_stall, 0);
			@(posedge hclk);
		end
	endtask
	// Empty refill with interrupt masked
	task automatic t_refill;
		int n;
		wr(`PFW_OFF_FLAGS_MASK, 32'h0);
		wr(`PFW_OFF_TABLE_PTR, 32'h18);
		arm(8'haa, 8'h86);
		chk(core_stall, 1);
		chk(flash_byte_en, 0);
		chk(flash_wdata, {8{8'hff}});
		// Latch write during the stall must be dropped
		@(posedge hclk);
		wr(`PFW_OFF_TABLE_LATCH, 32'h5a);
		wait_write(n);
		chk(u_flash.mem[3], {8{8'hff}});
		rd_chk(`PFW_OFF_TABLE_LATCH, 32'h37);
		chk(irq, 0);
		rd_chk(`PFW_OFF_FLAGS_TWO, 32'h10);
	endtask
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, failures, n_checks} = '0;
		hresetn = 1'b0;
		hsize = 3'b010;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_program();
		t_refused();
		t_refill();
		summarize();
	end
endmodule
